// ==== verif/ctrl_model.sv ====
// Controller model driving the synchronous pins of one port
`timescale 1ns/10ps
module ctrl_model (
   input  wire logic                   clock_i,
   input  wire logic                   go_i,
   input  wire logic                   hit_i,
   input  wire sdp_pkg::port_pins_type cmd_i,
   output sdp_pkg::port_pins_type      pins_o
);
   sdp_pkg::port_pins_type last_q = '0;
   // Remembered so idle cycles never repeat stale address or data
   always @(posedge clock_i) begin
      last_q <= pins_o;
   end
   // Idle: deselected, counter untouched, address and data inverted
   always_comb begin
      pins_o = cmd_i;
      pins_o.select_low_active_n = ~hit_i;
      if (!go_i) begin
         pins_o = '1;
         pins_o.select_high_active = 1'b0;
         pins_o.address = ~last_q.address;
         pins_o.wdata = ~last_q.wdata;
      end
   end
endmodule // ctrl_model

// ==== verif/sdp_ram_ports_assertions.sv ====
// Concurrent checks on the ports of the dual-port RAM port logic
`timescale 1ns/10ps
`include "sdp_consts.svh"
module sdp_ram_ports_checker (
   input wire logic                                    clock_i,
   input wire logic                                    rst_n_i,
   input wire logic                                    ce_i,
   input wire sdp_pkg::port_pins_type [`SDP_PORTS-1:0] pins_i,
   input wire logic [`SDP_PORTS-1:0]                   output_enable_n_i,
   input wire logic [`SDP_PORTS-1:0]                   output_stage_select_i,
   input wire sdp_pkg::data_type [`SDP_PORTS-1:0]      read_data_o,
   input wire sdp_pkg::lanes_type [`SDP_PORTS-1:0]     lane_drive_n_o,
   input wire logic [`SDP_PORTS-1:0]                   powered_down_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   logic [1:0] sel;
   logic [1:0] off0;
   logic       rd0, h0, ft, pl;
   // Port 0 runs flow-through and port 1 pipelined in the bench
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         sel[i] = !pins_i[i].select_low_active_n && pins_i[i].select_high_active;
      end
      rd0 = sel[0] && pins_i[0].write_n;
      off0 = {!rd0 || pins_i[0].upper_lane_enable_n, !rd0 || pins_i[0].lower_lane_enable_n};
      h0 = rd0 && pins_i[0].address_strobe_n && pins_i[0].count_advance_n
           && pins_i[0].counter_clear_n;
      ft = ce_i && !output_stage_select_i[0];
      pl = ce_i && output_stage_select_i[1];
   end
   a_oe_gates_lanes: assert property (
      output_enable_n_i[0] |-> lane_drive_n_o[0] == 2'h3)
      else $error("lanes driven with output enable off");
   a_deselect_sleeps: assert property (ce_i && !sel[0] |=> powered_down_o[0])
      else $error("no power down after deselect");
   a_select_wakes: assert property (ce_i && sel[0] |=> !powered_down_o[0])
      else $error("still powered down after select");
   a_idle_freezes: assert property (!ce_i |=> $stable(read_data_o[0]))
      else $error("outputs moved on a disabled edge");
   a_hold_keeps: assert property (
      (ce_i && h0)[*3] ##1 ce_i |=> $stable(read_data_o[0]))
      else $error("read data changed during hold");
   a_lane_off: assert property (ft[*3] ##1 ft |=>
      (lane_drive_n_o[0] & $past(off0, 2)) == $past(off0, 2))
      else $error("lane driven against previous controls");
   a_lane_on: assert property (ft[*2] ##1 (ft && off0 == 2'h0) ##1 ft |=>
      output_enable_n_i[0] || lane_drive_n_o[0] == 2'h0)
      else $error("lanes not driven after read");
   a_pipe_two_cycles: assert property (
      pl[*3] ##0 !sel[1] ##1 pl ##1 ce_i ##1 ce_i |=> lane_drive_n_o[1] == 2'h3)
      else $error("pipelined lanes on after one select");
   c_clear: cover property (ce_i && sel[0] && !pins_i[0].counter_clear_n);
   c_wake: cover property (pl && !sel[1] ##1 pl && sel[1] ##1 pl && sel[1]);
   c_hold: cover property ((ce_i && h0)[*3]);
endmodule // sdp_ram_ports_checker

bind sdp_ram_ports sdp_ram_ports_checker checker_u (.clock_i(clock_i), .rst_n_i(rst_n_i),
   .ce_i(ce_i), .pins_i(pins_i), .output_enable_n_i(output_enable_n_i),
   .output_stage_select_i(output_stage_select_i), .read_data_o(read_data_o),
   .lane_drive_n_o(lane_drive_n_o), .powered_down_o(powered_down_o));

// ==== verif/testbench.sv ====
// Directed bench for both ports of the dual-port RAM port logic
`timescale 1ns/10ps
module testbench;
   typedef struct packed {logic chk; sdp_pkg::lanes_type ln; sdp_pkg::data_type d;} exp_type;
   localparam exp_type OFF = '{1'b1, 2'h3, 18'h0};
   localparam exp_type NC = '0;
   logic                         clock_i = 1'b0;
   logic                         rst_n_i = 1'b0;
   logic                         ce_i = 1'b1;
   sdp_pkg::port_pins_type [1:0] cmd = '1;
   sdp_pkg::port_pins_type [1:0] pins;
   logic [1:0]                   go = 2'h0;
   logic [1:0]                   hit = 2'h3;
   logic [1:0]                   oe_n = 2'h0;
   logic [1:0]                   mode = 2'h2;
   sdp_pkg::data_type [1:0]      rdata;
   sdp_pkg::lanes_type [1:0]     lane_n;
   logic [1:0]                   pd;
   exp_type                      q[2][$];
   int                           num_errors = 0;
   int                           compares = 0;
   int                           cycles = 0;
   always #2.5 clock_i = ~clock_i;
   for (genvar i = 0; i < 2; i++) begin : g_ctrl
      ctrl_model cm_u (.clock_i(clock_i), .go_i(go[i]), .hit_i(hit[i]), .cmd_i(cmd[i]),
         .pins_o(pins[i]));
   end
   sdp_ram_ports dut_u (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .pins_i(pins),
      .output_enable_n_i(oe_n), .output_stage_select_i(mode), .read_data_o(rdata),
      .lane_drive_n_o(lane_n), .powered_down_o(pd));
   task automatic complete_run();
      if (num_errors == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [17:0] seen, input logic [17:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic exp_type rd(input logic [17:0] d);
      return '{1'b1, 2'h0, d};
   endfunction
   // Queue the outcome; flow-through shows it two cycles on, pipelined three
   task automatic settle(input int p, input exp_type e);
      exp_type o;
      #1;
      q[p].push_back(e);
      if (q[p].size() > 2 + p) begin
         o = q[p].pop_front();
         if (o.chk) begin
            check(lane_n[p], o.ln);
            if (o.ln == 2'h0) check(rdata[p], o.d);
         end
      end
   endtask
   // c holds write_n, strobe_n, advance_n, clear_n; ln holds the lane enables
   task automatic op(input int p, input logic [3:0] c, input logic [14:0] a,
                     input logic [17:0] d, input logic [1:0] ln, input exp_type e);
      @(posedge clock_i);
      go[p] <= 1'b1;
      hit[p] <= 1'b1;
      cmd[p] <= '{a, d, c[3], c[2], c[1], c[0], 1'b0, 1'b1, ln[1], ln[0]};
      settle(p, e);
   endtask
   task automatic idle(input int p, input exp_type e);
      @(posedge clock_i);
      go[p] <= 1'b0;
      settle(p, e);
   endtask
   // A hung run is cut short well past the directed sequence length
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 2000) begin
         num_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (5) @(posedge clock_i);
      rst_n_i <= 1'b1;
      op(0, 4'h3, 15'h0010, 18'h2a5c3, 2'h0, OFF);
      op(0, 4'h5, 15'h7fff, 18'h15a3c, 2'h0, OFF);
      op(0, 4'h5, 15'h7fff, 18'h3f00f, 2'h0, OFF);
      op(0, 4'h3, 15'h0012, 18'h0ff30, 2'h2, OFF);
      op(0, 4'h2, 15'h0055, 18'h12345, 2'h0, OFF);
      op(0, 4'hb, 15'h0010, 18'h0, 2'h0, rd(18'h2a5c3));
      op(0, 4'hd, 15'h0000, 18'h0, 2'h0, rd(18'h15a3c));
      op(0, 4'hd, 15'h0000, 18'h0, 2'h0, rd(18'h3f130));
      repeat (3) op(0, 4'hf, 15'h0001, 18'h0, 2'h0, rd(18'h3f130));
      op(0, 4'ha, 15'h0012, 18'h0, 2'h0, rd(18'h12345));
      op(0, 4'hb, 15'h0010, 18'h0, 2'h2, '{1'b1, 2'h2, 18'h0});
      // Only the low-active select drops, as for a bank that is not addressed
      @(posedge clock_i);
      hit[0] <= 1'b0;
      settle(0, OFF);
      check(pd[0], 1'b0);
      idle(0, OFF);
      check(pd[0], 1'b1);
      op(0, 4'hb, 15'h0011, 18'h0, 2'h0, rd(18'h15a3c));
      check(pd[0], 1'b1);
      op(0, 4'h3, 15'h0011, 18'h15a3c, 2'h0, OFF);
      repeat (2) op(0, 4'hf, 15'h0000, 18'h0, 2'h0, NC);
      @(posedge clock_i);
      oe_n[0] <= 1'b1;
      #1 check(lane_n[0], 2'h3);
      @(posedge clock_i);
      oe_n[0] <= 1'b0;
      #1 check(lane_n[0], 2'h0);
      q[0].delete();
      op(1, 4'hb, 15'h0010, 18'h0, 2'h0, OFF);
      check(pd[1], 1'b1);
      op(1, 4'hb, 15'h0011, 18'h0, 2'h0, rd(18'h15a3c));
      check(pd[1], 1'b0);
      op(1, 4'h3, 15'h0020, 18'h0beef, 2'h0, OFF);
      op(1, 4'hb, 15'h0010, 18'h0, 2'h0, rd(18'h2a5c3));
      op(1, 4'hb, 15'h0020, 18'h0, 2'h0, rd(18'h0beef));
      repeat (3) idle(1, NC);
      op(0, 4'hb, 15'h0020, 18'h0, 2'h0, rd(18'h0beef));
      repeat (2) idle(0, OFF);
      @(posedge clock_i);
      ce_i <= 1'b0;
      go[0] <= 1'b1;
      cmd[0].address <= 15'h0010;
      repeat (3) @(posedge clock_i);
      #1 check(rdata[0], 18'h0beef);
      check(lane_n[0], 2'h3);
      complete_run();
   end
endmodule // testbench

// ==== verilog/sdp_consts.svh ====
// Constants for the synchronous dual-port RAM port logic
`ifndef SDP_CONSTS_SVH
`define SDP_CONSTS_SVH

// Geometry
`define SDP_PORTS       2
`define SDP_ADDR_W      15
`define SDP_LANE_W      9
`define SDP_LANES       2
`define SDP_DATA_W      18

// Lane positions inside a data word and inside lane vectors
`define SDP_UPPER_LANE  1
`define SDP_LOWER_LANE  0

// Reset values
`define SDP_ADDR_RESET  15'h0000
`define SDP_DATA_RESET  18'h00000
`define SDP_LANES_OFF   2'h3

// Counter step
`define SDP_ADDR_STEP   15'h0001

`endif

// ==== verilog/sdp_mem_array.sv ====
// Dual-port storage array with per-lane writes and registered read data
`timescale 1ns/10ps
`include "sdp_consts.svh"

module sdp_mem_array #(
   parameter int ADDR_W = `SDP_ADDR_W,
   parameter int LANE_W = `SDP_LANE_W,
   parameter int LANES  = `SDP_LANES,
   parameter int PORTS  = `SDP_PORTS
) (
   input  wire logic                                  clock_i,
   input  wire logic                                  rst_n_i,
   input  wire logic                                  ce_i,
   input  wire logic [PORTS-1:0]                      rd_en_i,
   input  wire logic [PORTS-1:0][ADDR_W-1:0]          rd_addr_i,
   input  wire logic [PORTS-1:0][LANES-1:0]           wr_en_i,
   input  wire logic [PORTS-1:0][ADDR_W-1:0]          wr_addr_i,
   input  wire logic [PORTS-1:0][LANES-1:0][LANE_W-1:0] wr_data_i,
   output logic      [PORTS-1:0][LANES-1:0][LANE_W-1:0] rd_data_o
);

   logic [LANES-1:0][LANE_W-1:0] mem [2**ADDR_W];

   // Writes; walking downward lets the lowest port win a same-word collision
   always_ff @(posedge clock_i) begin
      if (ce_i) begin
         for (int p = PORTS - 1; p >= 0; p--) begin
            for (int l = 0; l < LANES; l++) begin
               if (wr_en_i[p][l]) begin
                  mem[wr_addr_i[p]][l] <= wr_data_i[p][l];
               end
            end
         end
      end
   end

   // Read data is registered and holds while a port is not reading
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rd_data_o <= '0;
      end else if (ce_i) begin
         for (int p = 0; p < PORTS; p++) begin
            if (rd_en_i[p]) begin
               rd_data_o[p] <= mem[rd_addr_i[p]];
            end
         end
      end
   end

endmodule // sdp_mem_array

// ==== verilog/sdp_pkg.sv ====
// Types shared by the dual-port RAM port logic and its verification models
package sdp_pkg;

`include "sdp_consts.svh"

   typedef logic [`SDP_ADDR_W-1:0] addr_type;
   typedef logic [`SDP_DATA_W-1:0] data_type;
   typedef logic [`SDP_LANES-1:0]  lanes_type;

   // Synchronous pins of one port, all sampled on the rising clock edge
   typedef struct packed {
      addr_type address;
      data_type wdata;
      logic     write_n;
      logic     address_strobe_n;
      logic     count_advance_n;
      logic     counter_clear_n;
      logic     select_low_active_n;
      logic     select_high_active;
      logic     upper_lane_enable_n;
      logic     lower_lane_enable_n;
   } port_pins_type;

   // Power and output reactivation state of one port
   typedef enum logic [1:0] {
      POWER_DOWN,
      WAKING,
      ACTIVE
   } power_state_type;

   // All state of one port
   typedef struct packed {
      port_pins_type   in;
      addr_type        counter;
      power_state_type power;
      logic            mode_meta;
      logic            mode_sync;
      lanes_type       pipe_on;
      data_type        pipe_data;
      lanes_type       out_off;
      data_type        out_data;
   } port_state_type;

   typedef struct packed {
      port_state_type [`SDP_PORTS-1:0] port;
   } state_type;

endpackage

// ==== verilog/sdp_ram_ports.sv ====
// Both symmetric ports of a synchronous dual-port static RAM
//
// How it works
// - Address, data and controls are registered on the rising clock edge.
// - Output enable gates the data drivers directly, bypassing clocked stages.
// - Address strobe low at the edge loads the external address.
// - Internal address is external address on strobe low, else counter value.
// - Count advance low with strobe high increments; writes hit the new address.
// - Strobe and count advance both high hold the address and read data.
// - Counter clear costs no cycle; an access may share the clear cycle.
// - Output drive follows controls sampled the cycle before (flow-through) or two cycles before (pipelined).
// - One deselected sample powers the port down.
// - Pipelined mode needs two selected cycles before outputs drive again.
// - Both ports are identical and may read and write the same word.
// - Dual selects give depth expansion; unaddressed banks stay quiet.
// - Each port's mode pin picks pipelined (high) or flow-through (low).
// - Deselect or high lane enable floats that lane after the next edge (flow-through) or the one after (pipelined).
`timescale 1ns/10ps
`include "sdp_consts.svh"

module sdp_ram_ports (
   input  wire logic                                   clock_i,
   input  wire logic                                   rst_n_i,
   input  wire logic                                   ce_i,
   input  wire sdp_pkg::port_pins_type [`SDP_PORTS-1:0] pins_i,
   input  wire logic [`SDP_PORTS-1:0]                  output_enable_n_i,
   input  wire logic [`SDP_PORTS-1:0]                  output_stage_select_i,
   output sdp_pkg::data_type [`SDP_PORTS-1:0]          read_data_o,
   output sdp_pkg::lanes_type [`SDP_PORTS-1:0]         lane_drive_n_o,
   output logic [`SDP_PORTS-1:0]                       powered_down_o
);

   // Idle values of the sampled pins: deselected, reading, counter left alone
   localparam sdp_pkg::port_pins_type PINS_RESET = '{
      address:             `SDP_ADDR_RESET,
      wdata:               `SDP_DATA_RESET,
      write_n:             1'b1,
      address_strobe_n:    1'b1,
      count_advance_n:     1'b1,
      counter_clear_n:     1'b1,
      select_low_active_n: 1'b1,
      select_high_active:  1'b0,
      upper_lane_enable_n: 1'b1,
      lower_lane_enable_n: 1'b1
   };

   // Reset state of one port: powered down, every lane floating
   localparam sdp_pkg::port_state_type PORT_RESET = '{
      in:        PINS_RESET,
      counter:   `SDP_ADDR_RESET,
      power:     sdp_pkg::POWER_DOWN,
      mode_meta: 1'b0,
      mode_sync: 1'b0,
      pipe_on:   2'h0,
      pipe_data: `SDP_DATA_RESET,
      out_off:   `SDP_LANES_OFF,
      out_data:  `SDP_DATA_RESET
   };

   // Both select pins must be in their active level
   function automatic logic selected(input sdp_pkg::port_pins_type pins);
      selected = !pins.select_low_active_n && pins.select_high_active;
   endfunction

   // Lane enables of a sampled pin set, one bit per lane, active high
   function automatic sdp_pkg::lanes_type lanes_on(input sdp_pkg::port_pins_type pins);
      lanes_on                  = 2'h0;
      lanes_on[`SDP_UPPER_LANE] = !pins.upper_lane_enable_n;
      lanes_on[`SDP_LOWER_LANE] = !pins.lower_lane_enable_n;
   endfunction

   sdp_pkg::state_type state_q;
   sdp_pkg::state_type state_d;

   // Storage array connections
   logic [`SDP_PORTS-1:0]                                    rd_en;
   logic [`SDP_PORTS-1:0][`SDP_ADDR_W-1:0]                   rd_addr;
   logic [`SDP_PORTS-1:0][`SDP_LANES-1:0]                    wr_en;
   logic [`SDP_PORTS-1:0][`SDP_ADDR_W-1:0]                   wr_addr;
   logic [`SDP_PORTS-1:0][`SDP_LANES-1:0][`SDP_LANE_W-1:0]   wr_data;
   logic [`SDP_PORTS-1:0][`SDP_LANES-1:0][`SDP_LANE_W-1:0]   rd_data;

   // One array shared by both ports so either may write while the other reads
   sdp_mem_array #(
      .ADDR_W (`SDP_ADDR_W),
      .LANE_W (`SDP_LANE_W),
      .LANES  (`SDP_LANES),
      .PORTS  (`SDP_PORTS)
   ) u_array (
      .clock_i   (clock_i),
      .rst_n_i   (rst_n_i),
      .ce_i      (ce_i),
      .rd_en_i   (rd_en),
      .rd_addr_i (rd_addr),
      .wr_en_i   (wr_en),
      .wr_addr_i (wr_addr),
      .wr_data_i (wr_data),
      .rd_data_o (rd_data)
   );

   // Next state of every port; the ports share this code and differ only in index
   always_comb begin
      sdp_pkg::port_pins_type pins;
      sdp_pkg::port_state_type cur;
      sdp_pkg::port_state_type nxt;
      sdp_pkg::lanes_type read_lanes;
      pins       = PINS_RESET;
      cur        = PORT_RESET;
      nxt        = PORT_RESET;
      read_lanes = 2'h0;
      state_d    = state_q;
      rd_en      = '0;
      rd_addr    = '0;
      wr_en      = '0;
      wr_addr    = '0;
      wr_data    = '0;
      for (int p = 0; p < `SDP_PORTS; p++) begin
         pins = pins_i[p];
         cur  = state_q.port[p];
         nxt  = cur;

         // Input register stage; its content steers the following cycle
         nxt.in = pins;

         // Address counter; clear outranks load, load outranks advance
         if (!pins.counter_clear_n) begin
            nxt.counter = `SDP_ADDR_RESET;
         end else if (!pins.address_strobe_n) begin
            nxt.counter = pins.address;
         end else if (!pins.count_advance_n) begin
            nxt.counter = cur.counter + `SDP_ADDR_STEP;
         end else begin
            nxt.counter = cur.counter;
         end

         // A single deselected sample drops the port; reselect climbs back
         if (!selected(pins)) begin
            nxt.power = sdp_pkg::POWER_DOWN;
         end else begin
            case (cur.power)
               sdp_pkg::POWER_DOWN: nxt.power = sdp_pkg::WAKING;
               sdp_pkg::WAKING:     nxt.power = sdp_pkg::ACTIVE;
               sdp_pkg::ACTIVE:     nxt.power = sdp_pkg::ACTIVE;
               default:             nxt.power = sdp_pkg::POWER_DOWN;
            endcase
         end

         // Mode pin is not tied to the clock, so it is synchronised first
         nxt.mode_meta = output_stage_select_i[p];
         nxt.mode_sync = cur.mode_meta;

         // Read at the address just formed; a deselected port leaves data held
         rd_en[p]   = selected(pins);
         rd_addr[p] = nxt.counter;

         // Writes use the registered address and data, one edge after sampling
         wr_addr[p] = cur.counter;
         wr_data[p] = cur.in.wdata;
         if (!cur.in.write_n && selected(cur.in)) begin
            wr_en[p] = lanes_on(cur.in);
         end

         // Lanes that the previous sample asked to be read out
         if (cur.in.write_n && selected(cur.in)) begin
            read_lanes = lanes_on(cur.in);
         end else begin
            read_lanes = 2'h0;
         end

         // Extra register stage used only in pipelined mode
         nxt.pipe_data = rd_data[p];
         if (cur.power == sdp_pkg::ACTIVE) begin
            nxt.pipe_on = read_lanes;
         end else begin
            nxt.pipe_on = 2'h0;
         end

         // Output register: pipelined adds a stage, flow-through skips it
         if (cur.mode_sync) begin
            nxt.out_data = cur.pipe_data;
            nxt.out_off  = ~cur.pipe_on;
         end else begin
            nxt.out_data = rd_data[p];
            nxt.out_off  = ~read_lanes;
         end

         state_d.port[p] = nxt;
      end
   end

   // The one state register; clock enable low freezes every port
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_q <= {`SDP_PORTS{PORT_RESET}};
      end else if (ce_i) begin
         state_q <= state_d;
      end
   end

   // Output pins; the enable is combined without a clock so bus turnaround is fast
   always_comb begin
      for (int p = 0; p < `SDP_PORTS; p++) begin
         read_data_o[p]    = state_q.port[p].out_data;
         lane_drive_n_o[p] = state_q.port[p].out_off
                             | {`SDP_LANES{output_enable_n_i[p]}};
         powered_down_o[p] = (state_q.port[p].power == sdp_pkg::POWER_DOWN);
      end
   end

   // Limitation: read and write of one word by one port at the same edge
   // return the old contents; a same-word write from both ports keeps port 0.

endmodule // sdp_ram_ports
